// ---- lcdc_pkg.sv ----
// lcdc_pkg: constants, field layout and carrier types of the display
// control register bank.
// assumes a single 100 MHz system clock and a plain register port.
//
// Function
// - controller starts frames only while enable is one
// - cleared enable finishes frame, then sets done
// - reset clears enable; controller starts disabled
// - mono zero selects colour, 12-bit entries
// - colour: 8 pins single, 16 dual; code drives 16 pins for active single colour too
// - mono: 4 or 8 lines single, 8 or 16 dual
// - dual panel presents two lines at once
// - dual panel uses both dma channels alternately
// - dual panel doubles the data pin usage; code keeps active colour at 16 and active mono without m8 at 8
// - mask bit one passes its status flag
// - active mode bypasses dither after palette
// - active mode size 11 gives 16-bit pixels
// - endian select picks first packed pixel
// - endian select picks first palette half-word
// - endian never reorders fields inside entries
// - mono four lane: bits 3:0 and 7:4
// - mono eight lane: both 8-bit buses
// - gap counter reloads after each dma burst that ends during palette loading
// - gap zero disables; applies only palette loading
// - reserved bits ignore writes, read zero
// - counter zero lets pending request burst four
package lcdc_pkg;
  // ==========================================================
  // register map
  localparam logic [31:0] CTRL_ADDR = 32'hC1000000;
  localparam logic [31:0] CTRL_RESET = 32'h00000000;
  localparam logic [31:0] CTRL_WMASK = 32'h000FF3BF;
  localparam int EN_B = 0;
  localparam int MONO_B = 1;
  localparam int DUAL_B = 2;
  localparam int DONE_M_B = 3;
  localparam int NEXT_M_B = 4;
  localparam int ERR_M_B = 5;
  localparam int ACT_B = 7;
  localparam int BE_B = 8;
  localparam int M8_B = 9;
  localparam int GAP_LO = 12;
  localparam int GAP_W = 8;
  localparam logic [1:0] PIX16 = 2'h3;
  localparam logic [2:0] BURST_WORDS = 3'h4;

  // ==========================================================
  // control fields as a carrier
  typedef struct packed {
    logic [GAP_W-1:0] gap;
    logic m8;
    logic be;
    logic act;
    logic err_m;
    logic next_m;
    logic done_m;
    logic dual;
    logic mono;
    logic en;
  } lcdc_ctrl_t;

  // lane usage derived from the mode
  typedef struct packed {
    logic up_lo;
    logic up_hi;
    logic lo_all;
  } lcdc_lanes_t;
endpackage : lcdc_pkg

// ---- lcdc_control_bank.sv ----
// lcdc_control_bank: display control register and what it steers:
// enable and frame shutdown, lane usage, pixel unpacking, palette
// half-word order, irq masking and the dma request gap counter.
// assumes frame and dma status events arrive on clk_sys as pulses.
module lcdc_control_bank #(
  parameter int GAP_W = lcdc_pkg::GAP_W
) (
  input wire logic clk_sys, // system clock, 100 MHz
  input wire logic reset, // synchronous, active high
  input wire logic [31:0] addr, // register byte address
  input wire logic [31:0] wdata, // write data
  input wire logic wr, // write strobe
  input wire logic rd, // read strobe
  output logic [31:0] rdata, // read data, cycle after rd
  input wire logic frame_end, // pulse: last pixel of frame out
  input wire logic next_evt, // pulse: base address reloadable
  input wire logic bus_fault_flag, // pulse: dma bus error
  input wire logic fifo_want, // level: input fifo wants words
  input wire logic pal_loading, // level: palette load in progress
  input wire logic dma_word, // pulse: one burst word done
  output logic dma_req, // level: dma burst request
  output logic frame_run, // level: frames may be produced
  output logic frame_done, // pulse: frame finished after off
  output logic irq_done, // level: masked done status
  output logic irq_next, // level: masked next status
  output logic irq_err, // level: masked error status
  output logic dither_on, // level: dither path in use
  output logic dual_chan, // level: second dma channel used
  output logic pix16, // level: 16-bit active pixels
  output lcdc_pkg::lcdc_lanes_t lanes, // data pin lanes driven
  input wire logic [1:0] pixel_size_field, // size code, pal entry 0
  input wire logic [31:0] fb_word, // frame buffer word
  input wire logic [2:0] slot, // pixel slot within word
  output logic [15:0] pixel, // unpacked pixel, registered
  input wire logic pal_half, // which palette entry in word
  output logic [15:0] pal_entry // palette entry, registered
);
  typedef struct packed {
    lcdc_pkg::lcdc_ctrl_t ctrl;
    logic running;
    logic stopping;
    logic st_done;
    logic st_next;
    logic st_err;
    logic [GAP_W-1:0] gap_cnt;
    logic [2:0] words;
    logic req;
    logic done_p;
    logic [31:0] rdata;
    logic [15:0] pixel;
    logic [15:0] pal;
  } lcdc_state_t;

  lcdc_state_t s_q, s_d;

  // ==========================================================
  // helpers
  // slot index for the current endian order
  function automatic logic [2:0] order(input logic be,
                                       input logic [2:0] i,
                                       input logic [2:0] n);
    order = be ? 3'(n - 3'h1 - i) : i;
  endfunction : order

  // ==========================================================
  // next state
  always_comb begin
    logic [31:0] wv;
    logic [2:0] k;
    wv = '0;
    k = '0;
    s_d = s_q;
    s_d.done_p = 1'b0;
    // register write: reserved bits dropped by mask
    if (wr && addr == lcdc_pkg::CTRL_ADDR) begin
      wv = wdata & lcdc_pkg::CTRL_WMASK;
      s_d.ctrl = lcdc_pkg::lcdc_ctrl_t'({wv[19:12], wv[9:7], wv[5:0]});
    end
    // read answer one cycle later; unmapped reads zero
    s_d.rdata = '0;
    if (rd && addr == lcdc_pkg::CTRL_ADDR) begin
      s_d.rdata[19:12] = s_q.ctrl.gap;
      s_d.rdata[9:7] = {s_q.ctrl.m8, s_q.ctrl.be, s_q.ctrl.act};
      s_d.rdata[5:0] = {s_q.ctrl.err_m, s_q.ctrl.next_m,
                        s_q.ctrl.done_m, s_q.ctrl.dual,
                        s_q.ctrl.mono, s_q.ctrl.en};
    end
    // frames start only on enable; clearing waits for frame end
    if (s_q.ctrl.en && !s_q.running) begin
      s_d.running = 1'b1;
    end
    if (s_q.running && !s_q.ctrl.en) begin
      s_d.stopping = 1'b1;
    end
    if (s_q.running && frame_end && (s_q.stopping || !s_q.ctrl.en)) begin
      s_d.running = 1'b0;
      s_d.stopping = 1'b0;
      s_d.done_p = 1'b1;
    end
    if (s_q.ctrl.en) begin
      s_d.stopping = 1'b0;
    end
    // sticky status; set wins over the mask-driven clear
    if (!s_q.ctrl.done_m) s_d.st_done = 1'b0;
    if (!s_q.ctrl.next_m) s_d.st_next = 1'b0;
    if (!s_q.ctrl.err_m) s_d.st_err = 1'b0;
    if (s_d.done_p) s_d.st_done = 1'b1;
    if (next_evt) s_d.st_next = 1'b1;
    if (bus_fault_flag) s_d.st_err = 1'b1;
    // request gap counter counts down between bursts
    if (s_q.gap_cnt != '0) begin
      s_d.gap_cnt = s_q.gap_cnt - 1'b1;
    end
    if (s_q.req && dma_word) begin
      s_d.words = s_q.words + 3'h1;
      if (s_q.words + 3'h1 == lcdc_pkg::BURST_WORDS) begin
        s_d.req = 1'b0;
        s_d.words = '0;
        if (pal_loading) begin
          s_d.gap_cnt = s_q.ctrl.gap;
        end
      end
    end
    if (!s_q.req && s_q.running && fifo_want
        && (s_q.gap_cnt == '0 || !pal_loading)) begin
      s_d.req = 1'b1;
    end
    // unpack: nibble, byte or half-word in endian order
    if (s_q.ctrl.act && pixel_size_field == lcdc_pkg::PIX16) begin
      k = order(s_q.ctrl.be, {2'h0, slot[0]}, 3'h2);
      s_d.pixel = k[0] ? fb_word[31:16] : fb_word[15:0];
    end else if (pixel_size_field == 2'h0) begin
      k = order(s_q.ctrl.be, slot, 3'h0); // 8 slots wrap to 7-i
      s_d.pixel = {12'h000, fb_word[{k, 2'h0} +: 4]};
    end else begin
      k = order(s_q.ctrl.be, {1'b0, slot[1:0]}, 3'h4);
      s_d.pixel = {8'h00, fb_word[{k[1:0], 3'h0} +: 8]};
    end
    // palette half-word order; fields inside stay put
    s_d.pal = (pal_half ^ s_q.ctrl.be) ? fb_word[31:16]
                                       : fb_word[15:0];
    if (reset) begin
      s_d = '0;
      s_d.ctrl = lcdc_pkg::lcdc_ctrl_t'(lcdc_pkg::CTRL_RESET);
    end
  end

  // ==========================================================
  // state register
  always_ff @(posedge clk_sys) begin
    s_q <= s_d;
  end

  // ==========================================================
  // outputs
  assign rdata = s_q.rdata;
  assign dma_req = s_q.req;
  assign frame_run = s_q.running;
  assign frame_done = s_q.done_p;
  // mask one passes the status flag
  assign irq_done = s_q.st_done & s_q.ctrl.done_m;
  assign irq_next = s_q.st_next & s_q.ctrl.next_m;
  assign irq_err = s_q.st_err & s_q.ctrl.err_m;
  assign dither_on = !s_q.ctrl.act;
  assign dual_chan = s_q.ctrl.dual;
  assign pix16 = s_q.ctrl.act && pixel_size_field == lcdc_pkg::PIX16;
  assign pixel = s_q.pixel;
  assign pal_entry = s_q.pal;

  // lane map: passive colour 8/16, mono 4/8, dual doubles usage; active colour 16, active mono 8, 16 with dual and m8
  always_comb begin
    lanes.up_lo = s_q.running;
    lanes.up_hi = s_q.running && (!s_q.ctrl.mono || s_q.ctrl.dual
                  || s_q.ctrl.m8 || s_q.ctrl.act);
    lanes.lo_all = s_q.running && ((!s_q.ctrl.mono
                   && (s_q.ctrl.dual || s_q.ctrl.act))
                   || (s_q.ctrl.mono && s_q.ctrl.m8
                   && s_q.ctrl.dual));
  end

  // ==========================================================
  // checks
  property p_off_stays;
    @(posedge clk_sys) disable iff (reset)
      !s_q.ctrl.en && !s_q.running |=> !s_q.running && !s_q.req;
  endproperty
  a_off_stays: assert property (p_off_stays) else $error("ran off");

  property p_done;
    @(posedge clk_sys) disable iff (reset)
      s_q.running && !s_q.ctrl.en && frame_end |=> frame_done;
  endproperty
  a_done: assert property (p_done) else $error("no done");

  property p_reset_off;
    @(posedge clk_sys) reset |=> !s_q.ctrl.en && !frame_run;
  endproperty
  a_reset_off: assert property (p_reset_off) else $error("rst en");

  property p_mask;
    @(posedge clk_sys) disable iff (reset)
      !s_q.ctrl.err_m |-> !irq_err;
  endproperty
  a_mask: assert property (p_mask) else $error("err leak");

  property p_gap;
    @(posedge clk_sys) disable iff (reset)
      s_q.gap_cnt != '0 && pal_loading |=> !$rose(dma_req);
  endproperty
  a_gap: assert property (p_gap) else $error("gap req");

  property p_reload;
    @(posedge clk_sys) disable iff (reset)
      $fell(dma_req) && $past(pal_loading) && !$past(wr)
      |-> s_q.gap_cnt == s_q.ctrl.gap;
  endproperty
  a_reload: assert property (p_reload) else $error("no reload");

  property p_rsv;
    @(posedge clk_sys) disable iff (reset)
      (rdata & ~lcdc_pkg::CTRL_WMASK) == '0;
  endproperty
  a_rsv: assert property (p_rsv) else $error("rsv set");

  // idle, running and wanting data: the request must follow next cycle
  logic running_ok;
  assign running_ok = s_q.running && fifo_want && !s_q.req
                      && !pal_loading && !dma_word;

  // half-words of the frame buffer word, for the unpack checks
  logic [15:0] fb_lo;
  logic [15:0] fb_hi;
  assign fb_lo = fb_word[15:0];
  assign fb_hi = fb_word[31:16];

  // last word index of a burst
  localparam logic [2:0] LAST_WORD = lcdc_pkg::BURST_WORDS - 3'h1;

  property p_go;
    @(posedge clk_sys) disable iff (reset)
      running_ok |=> dma_req;
  endproperty
  a_go: assert property (p_go) else $error("no req");

  property p_start;
    @(posedge clk_sys) disable iff (reset)
      s_q.ctrl.en && !s_q.stopping |=> frame_run;
  endproperty
  a_start: assert property (p_start) else $error("no run");

  property p_stop_holds;
    @(posedge clk_sys) disable iff (reset)
      s_q.running && !s_q.ctrl.en && !frame_end |=> frame_run;
  endproperty
  a_stop_holds: assert property (p_stop_holds) else $error("cut");

  property p_done_irq;
    @(posedge clk_sys) disable iff (reset)
      frame_done && s_q.ctrl.done_m |-> irq_done;
  endproperty
  a_done_irq: assert property (p_done_irq) else $error("done");

  property p_next_irq;
    @(posedge clk_sys) disable iff (reset)
      next_evt && s_q.ctrl.next_m && !wr |=> irq_next;
  endproperty
  a_next_irq: assert property (p_next_irq) else $error("next");

  property p_err_irq;
    @(posedge clk_sys) disable iff (reset)
      bus_fault_flag && s_q.ctrl.err_m && !wr |=> irq_err;
  endproperty
  a_err_irq: assert property (p_err_irq) else $error("err");

  property p_mask_done;
    @(posedge clk_sys) disable iff (reset)
      !s_q.ctrl.done_m |-> !irq_done;
  endproperty
  a_mask_done: assert property (p_mask_done) else $error("dleak");

  property p_mask_next;
    @(posedge clk_sys) disable iff (reset)
      !s_q.ctrl.next_m |-> !irq_next;
  endproperty
  a_mask_next: assert property (p_mask_next) else $error("nleak");

  property p_colour_dither;
    @(posedge clk_sys) disable iff (reset)
      !s_q.ctrl.act |-> dither_on;
  endproperty
  a_colour_dither: assert property (p_colour_dither) else $error("dth");

  property p_dual_chan;
    @(posedge clk_sys) disable iff (reset)
      s_q.ctrl.dual |-> dual_chan;
  endproperty
  a_dual_chan: assert property (p_dual_chan) else $error("chan");

  // pins stay quiet whenever no frame runs
  property p_lanes_off;
    @(posedge clk_sys) disable iff (reset)
      !frame_run |-> lanes == 3'h0;
  endproperty
  a_lanes_off: assert property (p_lanes_off) else $error("pins");

  property p_lane_dual;
    @(posedge clk_sys) disable iff (reset)
      frame_run && s_q.ctrl.dual |-> lanes.up_hi;
  endproperty
  a_lane_dual: assert property (p_lane_dual) else $error("dual");

  property p_lane_colour_dual;
    @(posedge clk_sys) disable iff (reset)
      frame_run && s_q.ctrl.dual && !s_q.ctrl.mono |-> lanes == 3'h7;
  endproperty
  a_lane_colour_dual: assert property (p_lane_colour_dual)
    else $error("col16");

  property p_lane_mono4;
    @(posedge clk_sys) disable iff (reset)
      frame_run && s_q.ctrl.mono && !s_q.ctrl.dual && !s_q.ctrl.m8
      && !s_q.ctrl.act |-> lanes == 3'h4;
  endproperty
  a_lane_mono4: assert property (p_lane_mono4) else $error("m4");

  property p_lane_mono8;
    @(posedge clk_sys) disable iff (reset)
      frame_run && s_q.ctrl.mono && s_q.ctrl.dual && s_q.ctrl.m8
      |-> lanes == 3'h7;
  endproperty
  a_lane_mono8: assert property (p_lane_mono8) else $error("m8");

  property p_pix16;
    @(posedge clk_sys) disable iff (reset)
      s_q.ctrl.act && pixel_size_field == lcdc_pkg::PIX16 |-> pix16;
  endproperty
  a_pix16: assert property (p_pix16) else $error("pix16");

  // two half-word pixels per word in active 16-bit mode
  property p_unpack_lo;
    @(posedge clk_sys) disable iff (reset)
      s_q.ctrl.act && pixel_size_field == lcdc_pkg::PIX16 && !slot[0]
      && !s_q.ctrl.be |=> pixel == $past(fb_lo);
  endproperty
  a_unpack_lo: assert property (p_unpack_lo) else $error("upk");

  property p_unpack_hi;
    @(posedge clk_sys) disable iff (reset)
      s_q.ctrl.act && pixel_size_field == lcdc_pkg::PIX16 && !slot[0]
      && s_q.ctrl.be |=> pixel == $past(fb_hi);
  endproperty
  a_unpack_hi: assert property (p_unpack_hi) else $error("upkbe");

  // palette half-word order follows the endian select only
  property p_pal_lo;
    @(posedge clk_sys) disable iff (reset)
      !pal_half && !s_q.ctrl.be |=> pal_entry == $past(fb_lo);
  endproperty
  a_pal_lo: assert property (p_pal_lo) else $error("pal");

  property p_pal_hi;
    @(posedge clk_sys) disable iff (reset)
      !pal_half && s_q.ctrl.be |=> pal_entry == $past(fb_hi);
  endproperty
  a_pal_hi: assert property (p_pal_hi) else $error("palbe");

  property p_burst_max;
    @(posedge clk_sys) disable iff (reset)
      s_q.words < lcdc_pkg::BURST_WORDS;
  endproperty
  a_burst_max: assert property (p_burst_max) else $error("words");

  // the request drops right after the last word of a burst
  property p_burst_drop;
    @(posedge clk_sys) disable iff (reset)
      s_q.req && dma_word && s_q.words == LAST_WORD |=> !dma_req;
  endproperty
  a_burst_drop: assert property (p_burst_drop) else $error("drop");

  property p_rd_idle;
    @(posedge clk_sys) disable iff (reset)
      !$past(rd) |-> rdata == '0;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("rdata");

  property p_dither;
    @(posedge clk_sys) disable iff (reset)
      s_q.ctrl.act |-> !dither_on;
  endproperty
  a_dither: assert property (p_dither) else $error("dither");

  c_stop: cover property (@(posedge clk_sys) frame_done);
  c_burst: cover property (@(posedge clk_sys) $fell(dma_req));
  c_irq: cover property (@(posedge clk_sys) irq_err);
  c_gap: cover property (@(posedge clk_sys) s_q.gap_cnt == 8'h01);
  c_be16: cover property (@(posedge clk_sys) pix16 && s_q.ctrl.be);
endmodule : lcdc_control_bank

// ---- lcdc_dma_partner.sv ----
// lcdc_dma_partner: memory side of the input fifo dma handshake.
// assumes dma_req is a level on clk_sys held until the burst ends.
module lcdc_dma_partner (
  input wire logic clk_sys, // system clock
  input wire logic [1:0] lag, // idle cycles before each word
  input wire logic dma_req, // burst request from the bank
  output logic dma_word // pulse: one word written
);
  timeunit 1ns;
  timeprecision 1ps;
  int words = 0;
  int idle = 0;
  initial dma_word = 1'b0;
  // ==========================================================
  // four words a burst; a slow memory inserts lag idle cycles
  always @(posedge clk_sys) begin
    dma_word <= 1'b0;
    if (dma_req !== 1'b1) begin
      words <= 0;
      idle <= 0;
    end else if (words < 4 && idle >= int'(lag)) begin
      dma_word <= 1'b1;
      words <= words + 1;
      idle <= 0;
    end else if (words < 4) begin
      idle <= idle + 1;
    end
  end
endmodule : lcdc_dma_partner

// ---- lcd_control_register_bank_test.sv ----
// lcd_control_register_bank_test: self-checking bench of the bank.
// assumes reads answer one cycle late and the bank never stalls.
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin \
  miscompares++; $display("BAD t=%0t got=%h exp=%h", $time, g, e); \
  end end
module lcd_control_register_bank_test;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [31:0] CA = lcdc_pkg::CTRL_ADDR;
  logic clk_sys = 1'b0, reset = 1'b1, wr = 1'b0, rd = 1'b0;
  logic [31:0] addr = 32'h0, wdata = 32'h0, fb_word = 32'h0, rdata;
  logic frame_end = 1'b0, next_evt = 1'b0, bus_fault_flag = 1'b0;
  logic fifo_want = 1'b0, pal_loading = 1'b0, pal_half = 1'b0;
  logic [1:0] pixel_size_field = 2'h0, lag = 2'h0;
  logic [2:0] slot = 3'h0;
  logic dma_word, dma_req, frame_run, frame_done, irq_done, irq_next;
  logic irq_err, dither_on, dual_chan, pix16;
  lcdc_pkg::lcdc_lanes_t lanes;
  logic [15:0] pixel, pal_entry;
  int miscompares = 0, checks_done = 0;
  lcdc_control_bank dut (.clk_sys(clk_sys), .reset(reset), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .frame_end(frame_end),
    .next_evt(next_evt), .bus_fault_flag(bus_fault_flag),
    .fifo_want(fifo_want), .pal_loading(pal_loading), .dma_word(dma_word),
    .dma_req(dma_req), .frame_run(frame_run), .frame_done(frame_done),
    .irq_done(irq_done), .irq_next(irq_next), .irq_err(irq_err),
    .dither_on(dither_on), .dual_chan(dual_chan), .pix16(pix16),
    .lanes(lanes), .pixel_size_field(pixel_size_field), .fb_word(fb_word),
    .slot(slot), .pixel(pixel), .pal_half(pal_half), .pal_entry(pal_entry));
  lcdc_dma_partner u_dma (.clk_sys(clk_sys), .lag(lag), .dma_req(dma_req),
    .dma_word(dma_word));
  // ==========================================================
  // 100 MHz clock; tasks start and end just after a rising edge
  always #5 clk_sys = ~clk_sys;
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
  endtask : tick
  // extra edge after the strobe so the next one never shares a step
  task automatic wr_reg(input logic [31:0] a, input logic [31:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    tick(1);
    wr <= 1'b0;
    tick(1);
  endtask : wr_reg
  task automatic chk_rd(input logic [31:0] a, input logic [31:0] e);
    addr <= a;
    rd <= 1'b1;
    tick(1);
    rd <= 1'b0;
    @(negedge clk_sys);
    `CHK(rdata, e)
    tick(1);
  endtask : chk_rd
  task automatic start(input logic [31:0] v);
    wr_reg(CA, v | 32'h1);
    tick(1);
    @(negedge clk_sys);
    `CHK(frame_run, 1'b1)
    tick(1);
  endtask : start
  // cleared enable must run on until the frame ends
  task automatic stop(input logic [31:0] v);
    int seen;
    wr_reg(CA, v & 32'hFFFFFFFE);
    tick(3);
    @(negedge clk_sys);
    `CHK(frame_run, 1'b1)
    tick(1);
    frame_end <= 1'b1;
    tick(1);
    frame_end <= 1'b0;
    seen = 0;
    repeat (4) begin
      @(negedge clk_sys);
      seen += int'(frame_done === 1'b1);
      tick(1);
    end
    `CHK(seen, 1)
    `CHK(frame_run, 1'b0)
    `CHK(lanes, 3'h0)
  endtask : stop
  task automatic t_reg;
    int hits;
    chk_rd(CA, 32'h0); // reset value
    `CHK(frame_run, 1'b0)
    wr_reg(CA, 32'hFFFFFFFE);
    chk_rd(CA, 32'h000FF3BE);
    chk_rd(CA + 32'h4, 32'h0);
    wr_reg(CA, 32'h0);
    fifo_want <= 1'b1;
    hits = 0;
    repeat (8) begin
      @(negedge clk_sys);
      hits += int'(dma_req === 1'b1);
    end
    `CHK(hits, 0)
    tick(1);
    fifo_want <= 1'b0;
    $display("t_reg done");
  endtask : t_reg
  task automatic t_irq(input logic [31:0] m, input logic [2:0] e);
    wr_reg(CA, m);
    next_evt <= 1'b1;
    bus_fault_flag <= 1'b1;
    tick(1);
    next_evt <= 1'b0;
    bus_fault_flag <= 1'b0;
    tick(1);
    @(negedge clk_sys);
    `CHK({irq_done, irq_next, irq_err}, e)
    tick(1);
    $display("t_irq done");
  endtask : t_irq
  task automatic t_modes;
    logic [31:0] c [6] = '{32'h8, 32'h4, 32'h2, 32'h6, 32'h202, 32'h80};
    logic [2:0] l [6] = '{3'h6, 3'h7, 3'h4, 3'h6, 3'h6, 3'h7};
    for (int i = 0; i < 6; i++) begin
      start(c[i]);
      `CHK(lanes, l[i])
      `CHK(dither_on, !c[i][7])
      `CHK(dual_chan, c[i][2])
      stop(c[i]);
      `CHK(irq_done, c[i][3])
    end
    $display("t_modes done");
  endtask : t_modes
  task automatic t_unpack(input logic [31:0] c, input logic [2:0] s,
      input logic h, input logic [1:0] z, input logic [15:0] e);
    wr_reg(CA, c);
    fb_word <= 32'h1234ABCD;
    pixel_size_field <= z;
    slot <= s;
    pal_half <= h;
    tick(2);
    @(negedge clk_sys);
    `CHK(pix16, z == 2'h3)
    `CHK(pixel, e)
    `CHK(pal_entry, e)
    tick(1);
    $display("t_unpack done");
  endtask : t_unpack
  // idle span between bursts must respect the programmed gap
  task automatic t_dma(input logic [7:0] g, input logic p,
      input logic [1:0] lg, input int lo, input int hi);
    int n;
    int w;
    start({12'h0, g, 12'h0});
    pal_loading <= p;
    lag <= lg;
    fifo_want <= 1'b1;
    n = 0;
    w = 0;
    @(negedge clk_sys);
    while (dma_req !== 1'b1 && n < 20) begin
      @(negedge clk_sys);
      n++;
    end
    while (dma_req === 1'b1 && n < 80) begin
      w += int'(dma_word === 1'b1);
      @(negedge clk_sys);
      n++;
    end
    `CHK(w, 4)
    n = 0;
    while (dma_req !== 1'b1 && n < 300) begin
      @(negedge clk_sys);
      n++;
    end
    `CHK(n >= lo && n <= hi, 1'b1)
    tick(1);
    fifo_want <= 1'b0;
    for (n = 0; n < 40 && dma_req === 1'b1; n++) tick(1);
    stop({12'h0, g, 12'h0});
    $display("t_dma done");
  endtask : t_dma
  task automatic close_out;
    $display("checks %0d miscompares %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : close_out
  // ==========================================================
  // main sequence and watchdog
  initial begin
    tick(4);
    reset <= 1'b0;
    tick(1);
    t_reg();
    t_irq(32'h30, 3'h3);
    t_irq(32'h0, 3'h0);
    t_modes();
    t_unpack(32'h80, 3'h0, 1'b0, 2'h3, 16'hABCD);
    t_unpack(32'h80, 3'h1, 1'b1, 2'h3, 16'h1234);
    t_unpack(32'h180, 3'h0, 1'b0, 2'h3, 16'h1234);
    t_unpack(32'h180, 3'h1, 1'b1, 2'h3, 16'hABCD);
    t_dma(8'h03, 1'b1, 2'h0, 3, 7);
    t_dma(8'h03, 1'b0, 2'h1, 0, 3);
    t_dma(8'h00, 1'b1, 2'h2, 0, 3);
    t_dma(8'hFF, 1'b1, 2'h0, 255, 259);
    close_out();
  end
  initial begin
    #200000;
    miscompares++;
    close_out();
  end
endmodule : lcd_control_register_bank_test
